// >>> hdl/cps_pkg.sv
// Shared constants for the control port and sideband pin block.
package cps_pkg;
   // ********************************************************************
   // Control port constants.
   // ********************************************************************
   localparam logic [3:0] I2C_ADDR_HI = 4'h4;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int SYNC_W = 7;
   localparam int SY_SCL = 0;
   localparam int SY_SDA = 1;
   localparam int SY_SEL = 2;
   localparam int SY_AD1 = 3;
   localparam int SY_AD2 = 4;
   localparam int SY_BLK = 5;
   localparam int SY_USR = 6;

   // ********************************************************************
   // Interrupt trigger modes, event count and block-start timing.
   // ********************************************************************
   localparam logic [1:0] TRIG_ARRIVE = 2'h0;
   localparam logic [1:0] TRIG_REMOVE = 2'h1;
   localparam logic [1:0] TRIG_LEVEL = 2'h2;
   localparam int NUM_EVENTS = 8;
   localparam logic [1:0] BLOCK_SYNC_MIN_CYC = 2'h3;

   typedef enum logic [2:0] {
      ST_IDLE, ST_CMD, ST_ACK, ST_DATA, ST_DONE
   } cps_state_t;
endpackage

// >>> hdl/cps_sync.sv
// Two-stage synchroniser for a group of asynchronous pins.
`timescale 1ns/1ps
module cps_sync #(
   parameter int W = 1
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Pins and their synchronised copies.
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);
   // ********************************************************************
   // Two flip-flops per bit.
   // ********************************************************************
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_r;
         logic hold_r;
         // The first stage feeds only the second stage.
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               meta_r <= 1'b0;
               hold_r <= 1'b0;
            end else begin
               meta_r <= asyncIn[i];
               hold_r <= meta_r;
            end
         end
         // Each bit has a single process behind it.
         assign syncOut[i] = hold_r;
      end
   endgenerate
endmodule

// >>> hdl/cps_sideband.sv
// Control port protocol select, interrupt pin and block-start pin logic.
// What this block does
// R1: Select falling edge switches port to SPI.
// R2: Without such edge, port is I2C slave.
// R3: I2C address uses address pins as bits.
// R4: Host ties address-2 pin fixed in SPI.
// R5: SPI traffic ignored while select is high.
// R6: SPI command in on data-in, reads out.
// R7: Host clock shifts bits both directions.
// R8: I2C data line only pulled low.
// R9: Each interrupt source has own mask.
// R10: Interrupt causes readable as status byte.
// R11: Interrupt polarity and open-drain are selectable.
// R12: Interrupt holds until read and status clear.
// R13: Block-start output high on first sub-frame.
// R14: Three-cycle high input restarts block next.
// R15: User bits optionally come from pin.
// R16: Per-source trigger: arrival, removal, level.
// R17: SPI selection stays until reset.
`timescale 1ns/1ps
module cps_sideband
   import cps_pkg::*;
#(
   parameter int NEV = NUM_EVENTS
) (
   // Clock (master clock) and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Control port pins.
   input wire logic ctlSerClock,
   input wire logic addr0OrSelectPin,
   input wire logic addrPin1CtlSerIn,
   input wire logic addrPin2,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   output logic spiModeActive,
   // Interrupt sources, configuration and pin.
   input wire logic [NEV-1:0] eventCond,
   input wire logic [NEV-1:0] intMask,
   input wire logic [2*NEV-1:0] intTrigMode,
   input wire logic intActiveHigh,
   input wire logic intOpenDrain,
   output logic [NEV-1:0] intStatus,
   output logic intOut,
   output logic intOe,
   // Block-start pin and transmitter side.
   input wire logic blockStartIsInput,
   input wire logic blockStartSyncIn,
   output logic blockStartSyncOut,
   output logic blockStartSyncOe,
   input wire logic subframeStart,
   input wire logic subframeIsFirst,
   output logic blockRestart,
   // User bit source.
   input wire logic userFromPin,
   input wire logic userPin,
   input wire logic userBufBit,
   output logic userBitOut
);
   // ********************************************************************
   // Pin synchronisation and edge detection.
   // ********************************************************************
   logic [SYNC_W-1:0] pinsAsync;
   logic [SYNC_W-1:0] pinsSync;
   logic [SYNC_W-1:0] pinsPrev_r;
   logic [1:0] fill_r, fill_nxt;
   logic primed;
   logic sclRise, sclFall, sdaRise, sdaFall, selFall;
   logic i2cStart, i2cStop, dataIn;

   assign pinsAsync = {userPin, blockStartSyncIn, addrPin2, addrPin1CtlSerIn,
                       addr0OrSelectPin, sdaIn, ctlSerClock};

   cps_sync #(.W(SYNC_W)) uSync (
      .clk(clk),
      .rst_b(rst_b),
      .asyncIn(pinsAsync),
      .syncOut(pinsSync)
   );

   // The synchroniser comes out of reset low while idle pins are high,
   // so edges are ignored until both it and the history hold real levels.
   assign primed = &fill_r;

   always_comb begin
      fill_nxt = primed ? fill_r : fill_r + 2'h1;
   end

   // Previous synchronised levels for edge detection.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pinsPrev_r <= {SYNC_W{1'b1}};
         fill_r <= 2'h0;
      end else begin
         pinsPrev_r <= pinsSync;
         fill_r <= fill_nxt;
      end
   end

   // Edges of the host clock, data line and select pin.
   always_comb begin
      sclRise = primed & pinsSync[SY_SCL] & ~pinsPrev_r[SY_SCL];
      sclFall = primed & ~pinsSync[SY_SCL] & pinsPrev_r[SY_SCL];
      sdaRise = primed & pinsSync[SY_SDA] & ~pinsPrev_r[SY_SDA];
      sdaFall = primed & ~pinsSync[SY_SDA] & pinsPrev_r[SY_SDA];
      selFall = primed & ~pinsSync[SY_SEL] & pinsPrev_r[SY_SEL];
      i2cStart = pinsSync[SY_SCL] & pinsPrev_r[SY_SCL] & sdaFall;
      i2cStop = pinsSync[SY_SCL] & pinsPrev_r[SY_SCL] & sdaRise;
   end

   // ********************************************************************
   // Protocol selection.
   // ********************************************************************
   logic spiMode_r, spiMode_nxt;

   // A select falling edge latches SPI until reset; otherwise I2C.
   always_comb begin
      spiMode_nxt = spiMode_r | selFall; // R1 R17 R2
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         spiMode_r <= 1'b0;
      end else begin
         spiMode_r <= spiMode_nxt;
      end
   end

   assign spiModeActive = spiMode_r;
   assign dataIn = spiMode_r ? pinsSync[SY_AD1] : pinsSync[SY_SDA]; // R6

   // ********************************************************************
   // Serial control engine: command byte in, status byte out.
   // ********************************************************************
   cps_state_t state_r, state_nxt;
   logic [3:0] bitCnt_r, bitCnt_nxt;
   logic [7:0] shiftIn_r, shiftIn_nxt;
   logic [7:0] shiftOut_r, shiftOut_nxt;
   logic [NEV-1:0] snap_r, snap_nxt;
   logic sdaLow_r, sdaLow_nxt;
   logic spiOut_r, spiOut_nxt;
   logic statusRead;
   logic [6:0] ownAddr;
   logic [7:0] statusByte;

   assign ownAddr = {I2C_ADDR_HI, pinsSync[SY_AD2], pinsSync[SY_AD1],
                     pinsSync[SY_SEL]}; // R3
   assign statusByte = 8'(intStatus); // R10

   // Next-state logic for both protocols on the host's clock edges.
   always_comb begin
      state_nxt = state_r;
      bitCnt_nxt = bitCnt_r;
      shiftIn_nxt = shiftIn_r;
      shiftOut_nxt = shiftOut_r;
      snap_nxt = snap_r;
      sdaLow_nxt = sdaLow_r;
      spiOut_nxt = spiOut_r;
      statusRead = 1'b0;
      if (!spiMode_r && i2cStart) begin
         state_nxt = ST_CMD;
         bitCnt_nxt = 4'h0;
         sdaLow_nxt = 1'b0;
      end else if (!spiMode_r && i2cStop) begin
         state_nxt = ST_IDLE;
         sdaLow_nxt = 1'b0;
      end else if (selFall) begin // R1
         state_nxt = ST_CMD;
         bitCnt_nxt = 4'h0;
      end else if (spiMode_r && pinsSync[SY_SEL]) begin
         state_nxt = ST_IDLE; // R5
         spiOut_nxt = 1'b0;
      end else begin
         case (state_r)
            ST_CMD: begin
               if (sclRise && bitCnt_r != BYTE_BITS) begin
                  shiftIn_nxt = {shiftIn_r[6:0], dataIn}; // R7
                  bitCnt_nxt = bitCnt_r + 4'h1;
               end else if (sclFall && bitCnt_r == BYTE_BITS) begin
                  bitCnt_nxt = 4'h0;
                  shiftOut_nxt = statusByte;
                  snap_nxt = intStatus;
                  if (spiMode_r) begin
                     state_nxt = shiftIn_r[0] ? ST_DATA : ST_DONE;
                     spiOut_nxt = shiftIn_r[0] & statusByte[7]; // R6
                  end else if (shiftIn_r[7:1] == ownAddr) begin
                     state_nxt = ST_ACK;
                     sdaLow_nxt = 1'b1; // R8
                  end else begin
                     state_nxt = ST_IDLE;
                  end
               end
            end
            ST_ACK: begin
               if (sclFall) begin
                  state_nxt = shiftIn_r[0] ? ST_DATA : ST_DONE;
                  sdaLow_nxt = shiftIn_r[0] & ~shiftOut_r[7]; // R8
               end
            end
            ST_DATA: begin
               if (sclRise) begin
                  bitCnt_nxt = bitCnt_r + 4'h1;
                  statusRead = (bitCnt_r == BYTE_BITS - 4'h1);
               end else if (sclFall) begin
                  shiftOut_nxt = {shiftOut_r[6:0], 1'b0}; // R7
                  if (bitCnt_r == BYTE_BITS) begin
                     state_nxt = ST_DONE;
                     sdaLow_nxt = 1'b0;
                     spiOut_nxt = 1'b0;
                  end else begin
                     sdaLow_nxt = ~spiMode_r & ~shiftOut_r[6];
                     spiOut_nxt = spiMode_r & shiftOut_r[6];
                  end
               end
            end
            default: begin
               sdaLow_nxt = sdaLow_r & ~sclFall;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_r <= ST_IDLE;
         bitCnt_r <= 4'h0;
         shiftIn_r <= 8'h00;
         shiftOut_r <= 8'h00;
         snap_r <= '0;
         sdaLow_r <= 1'b0;
         spiOut_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         bitCnt_r <= bitCnt_nxt;
         shiftIn_r <= shiftIn_nxt;
         shiftOut_r <= shiftOut_nxt;
         snap_r <= snap_nxt;
         sdaLow_r <= sdaLow_nxt;
         spiOut_r <= spiOut_nxt;
      end
   end

   // Shared data pin: active driver in SPI, pull-low only in I2C.
   assign sdaOut = spiMode_r ? spiOut_r : 1'b0; // R8
   assign sdaOe = spiMode_r ? ~pinsSync[SY_SEL] : sdaLow_r; // R5

   // ********************************************************************
   // Interrupt status, masking and pin.
   // ********************************************************************
   logic [NEV-1:0] condPrev_r, condPrev_nxt;
   logic [NEV-1:0] status_r, status_nxt;
   logic [NEV-1:0] trig;
   logic intAct_r, intAct_nxt;
   logic readSeen_r, readSeen_nxt;

   genvar e;
   generate
      for (e = 0; e < NEV; e++) begin : g_ev
         // Trigger detection per source.
         always_comb begin
            case (intTrigMode[2*e +: 2]) // R16
               TRIG_ARRIVE: trig[e] = eventCond[e] & ~condPrev_r[e];
               TRIG_REMOVE: trig[e] = ~eventCond[e] & condPrev_r[e];
               TRIG_LEVEL: trig[e] = eventCond[e];
               default: trig[e] = 1'b0;
            endcase
         end
      end
   endgenerate

   // Sticky status: a new event wins over the clear by a read.
   always_comb begin
      condPrev_nxt = eventCond;
      status_nxt = trig | (status_r & ~(statusRead ? snap_r : '0)); // R10
      readSeen_nxt = intAct_r & (readSeen_r | statusRead);
      intAct_nxt = intAct_r;
      if (|(status_r & intMask)) begin
         intAct_nxt = 1'b1; // R9
      end else if (intAct_r && readSeen_r && status_r == '0) begin
         intAct_nxt = 1'b0; // R12
         readSeen_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         condPrev_r <= '0;
         status_r <= '0;
         intAct_r <= 1'b0;
         readSeen_r <= 1'b0;
      end else begin
         condPrev_r <= condPrev_nxt;
         status_r <= status_nxt;
         intAct_r <= intAct_nxt;
         readSeen_r <= readSeen_nxt;
      end
   end

   assign intStatus = status_r;
   // Level follows polarity; open drain drives only the low level.
   assign intOut = intAct_r ~^ intActiveHigh; // R11
   assign intOe = ~intOpenDrain | ~intOut; // R11

   // ********************************************************************
   // Block-start pin and user bit source.
   // ********************************************************************
   logic [1:0] highCnt_r, highCnt_nxt;
   logic restartReq_r, restartReq_nxt;
   logic blkOut_r, blkOut_nxt;
   logic restart_r, restart_nxt;
   logic user_r, user_nxt;

   // Output marks the first sub-frame; input requests a restart.
   always_comb begin
      highCnt_nxt = 2'h0;
      restartReq_nxt = restartReq_r;
      blkOut_nxt = blkOut_r;
      restart_nxt = 1'b0;
      user_nxt = userFromPin ? pinsSync[SY_USR] : userBufBit; // R15
      if (blockStartIsInput) begin
         blkOut_nxt = 1'b0;
         if (pinsSync[SY_BLK]) begin
            highCnt_nxt = (highCnt_r == BLOCK_SYNC_MIN_CYC) ?
                          highCnt_r : highCnt_r + 2'h1;
         end
         if (highCnt_nxt == BLOCK_SYNC_MIN_CYC) begin
            restartReq_nxt = 1'b1; // R14
         end
         if (subframeStart && restartReq_r) begin
            restart_nxt = 1'b1; // R14
            restartReq_nxt = 1'b0;
         end
      end else begin
         restartReq_nxt = 1'b0;
         if (subframeStart) begin
            blkOut_nxt = subframeIsFirst; // R13
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         highCnt_r <= 2'h0;
         restartReq_r <= 1'b0;
         blkOut_r <= 1'b0;
         restart_r <= 1'b0;
         user_r <= 1'b0;
      end else begin
         highCnt_r <= highCnt_nxt;
         restartReq_r <= restartReq_nxt;
         blkOut_r <= blkOut_nxt;
         restart_r <= restart_nxt;
         user_r <= user_nxt;
      end
   end

   assign blockStartSyncOut = blkOut_r;
   assign blockStartSyncOe = ~blockStartIsInput;
   assign blockRestart = restart_r;
   assign userBitOut = user_r;
endmodule

// >>> verification/cps_sideband_monitor.sv
// Concurrent checks on the ports of the sideband block.
`timescale 1ns/1ps
module cps_sideband_monitor
   import cps_pkg::*;
#(
   parameter int NEV = NUM_EVENTS
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_b,
   // Control port.
   input wire logic addr0OrSelectPin,
   input wire logic sdaOut,
   input wire logic sdaOe,
   input wire logic spiModeActive,
   // Interrupt.
   input wire logic [NEV-1:0] eventCond,
   input wire logic [NEV-1:0] intMask,
   input wire logic [2*NEV-1:0] intTrigMode,
   input wire logic intActiveHigh,
   input wire logic intOpenDrain,
   input wire logic [NEV-1:0] intStatus,
   input wire logic intOut,
   input wire logic intOe,
   // Block start and user bit.
   input wire logic blockStartIsInput,
   input wire logic blockStartSyncOut,
   input wire logic subframeStart,
   input wire logic subframeIsFirst,
   input wire logic blockRestart,
   input wire logic userFromPin,
   input wire logic userBufBit,
   input wire logic userBitOut
);
   // ********
   // Properties, all on the master clock.
   // ********
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // A select fall while the port is still in its default mode.
   sequence s_sel_fall;
      !spiModeActive ##1 $fell(addr0OrSelectPin);
   endsequence
   a_sel_to_spi: assert property (s_sel_fall |-> ##[1:5] spiModeActive)
      else $error("select fall did not enter serial mode");
   a_spi_sticky: assert property (spiModeActive |=> spiModeActive)
      else $error("serial mode dropped without reset");
   a_i2c_low_only: assert property (!spiModeActive |-> !sdaOut)
      else $error("data pin driven high in address mode");
   a_spi_desel: assert property (spiModeActive && addr0OrSelectPin[*5]
      |-> !sdaOe)
      else $error("data pin driven while deselected");
   a_trig_arrive: assert property ($rose(eventCond[0]) &&
      intTrigMode[1:0] == TRIG_ARRIVE |=> intStatus[0])
      else $error("arrival trigger missed");
   a_trig_remove: assert property ($fell(eventCond[1]) &&
      intTrigMode[3:2] == TRIG_REMOVE |=> intStatus[1])
      else $error("removal trigger missed");
   a_trig_level: assert property (eventCond[2] &&
      intTrigMode[5:4] == TRIG_LEVEL |=> intStatus[2])
      else $error("level trigger missed");
   a_int_raise: assert property (|(intStatus & intMask)
      |=> intOut == intActiveHigh)
      else $error("unmasked status did not raise interrupt");
   a_int_hold: assert property (intOut == intActiveHigh && |intStatus
      |=> intOut == intActiveHigh)
      else $error("interrupt dropped with status pending");
   a_int_drive: assert property (intOe == (!intOpenDrain || !intOut))
      else $error("interrupt drive enable wrong");
   a_blk_out: assert property (subframeStart && !blockStartIsInput
      |=> blockStartSyncOut == $past(subframeIsFirst))
      else $error("block start output wrong");
   a_blk_restart: assert property (blockRestart
      |-> $past(subframeStart) && $past(blockStartIsInput))
      else $error("restart without sub-frame start");
   a_user_buf: assert property (!userFromPin
      |=> userBitOut == $past(userBufBit))
      else $error("user bit not from buffer");
endmodule
bind cps_sideband cps_sideband_monitor #(.NEV(NEV)) u_mon (
   .clk(clk), .rst_b(rst_b), .addr0OrSelectPin(addr0OrSelectPin),
   .sdaOut(sdaOut), .sdaOe(sdaOe), .spiModeActive(spiModeActive),
   .eventCond(eventCond), .intMask(intMask), .intTrigMode(intTrigMode),
   .intActiveHigh(intActiveHigh), .intOpenDrain(intOpenDrain),
   .intStatus(intStatus), .intOut(intOut), .intOe(intOe),
   .blockStartIsInput(blockStartIsInput),
   .blockStartSyncOut(blockStartSyncOut), .subframeStart(subframeStart),
   .subframeIsFirst(subframeIsFirst), .blockRestart(blockRestart),
   .userFromPin(userFromPin), .userBufBit(userBufBit),
   .userBitOut(userBitOut));

// >>> verification/cps_host.sv
// Host controller model driving the control port pins.
`timescale 1ns/1ps
module cps_host (
   // Control port pins.
   output logic ctlSerClock,
   output logic selPin,
   output logic serIn,
   output logic sdaLow,
   input wire logic sdaLine
);
   // Pins idle high; serIn doubles as a fixed address bit.
   initial begin
      ctlSerClock = 1'b1;
      selPin = 1'b1;
      serIn = 1'b1;
      sdaLow = 1'b0;
   end
   // Sends an address byte between start and stop, returns the ack.
   task automatic i2c_addr(input logic [7:0] b, output logic ack);
      #80 sdaLow = 1'b1;
      #160 ctlSerClock = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         #80 sdaLow = ~b[i];
         #80 ctlSerClock = 1'b1;
         #160 ctlSerClock = 1'b0;
      end
      #80 sdaLow = 1'b0;
      #80 ack = ~sdaLine;
      ctlSerClock = 1'b1;
      #160 ctlSerClock = 1'b0;
      #80 sdaLow = 1'b1;
      #80 ctlSerClock = 1'b1;
      #80 sdaLow = 1'b0;
      #160;
   endtask
   // Selects the port, sends the read command, shifts in one byte.
   task automatic spi_read(output logic [7:0] st);
      ctlSerClock = 1'b0;
      #160 selPin = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         #80 serIn = (i == 0);
         #80 ctlSerClock = 1'b1;
         #160 ctlSerClock = 1'b0;
      end
      for (int i = 7; i >= 0; i--) begin
         #160 st[i] = sdaLine;
         ctlSerClock = 1'b1;
         #160 ctlSerClock = 1'b0;
      end
      #160 selPin = 1'b1;
      ctlSerClock = 1'b1;
      #160;
   endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench for the sideband block.
`timescale 1ns/1ps
module tb_top
   import cps_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic ctlSerClock, selPin, serIn, sdaLow, sdaLine, addrPin2, ack;
   logic sdaOut, sdaOe, spiModeActive, intActiveHigh, intOpenDrain;
   logic intOut, intOe, blockStartIsInput, blockStartSyncIn, blkOut;
   logic blkOe, subframeStart, subframeIsFirst, blockRestart;
   logic userFromPin, userPin, userBufBit, userBitOut;
   logic [7:0] eventCond, intMask, intStatus, st;
   logic [15:0] intTrigMode;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   // Clock, pulled-up shared data pin, host model and device.
   always #20 clk = ~clk;
   assign sdaLine = sdaLow ? 1'b0 : (sdaOe ? sdaOut : 1'b1);
   cps_host u_host (.ctlSerClock(ctlSerClock), .selPin(selPin),
      .serIn(serIn), .sdaLow(sdaLow), .sdaLine(sdaLine));
   cps_sideband u_dut (.clk(clk), .rst_b(rst_b),
      .ctlSerClock(ctlSerClock), .addr0OrSelectPin(selPin),
      .addrPin1CtlSerIn(serIn), .addrPin2(addrPin2), .sdaIn(sdaLine),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .spiModeActive(spiModeActive),
      .eventCond(eventCond), .intMask(intMask), .intTrigMode(intTrigMode),
      .intActiveHigh(intActiveHigh), .intOpenDrain(intOpenDrain),
      .intStatus(intStatus), .intOut(intOut), .intOe(intOe),
      .blockStartIsInput(blockStartIsInput),
      .blockStartSyncIn(blockStartSyncIn), .blockStartSyncOut(blkOut),
      .blockStartSyncOe(blkOe), .subframeStart(subframeStart),
      .subframeIsFirst(subframeIsFirst), .blockRestart(blockRestart),
      .userFromPin(userFromPin), .userPin(userPin),
      .userBufBit(userBufBit), .userBitOut(userBitOut));
   // ********
   // Helpers.
   // ********
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   // Pulses one sub-frame start.
   task automatic sub(input logic first);
      subframeIsFirst = first;
      subframeStart = 1'b1;
      tick(1);
      subframeStart = 1'b0;
   endtask
   task automatic results();
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // Cuts a hung run short.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         $display("BAD %0t timeout", $time);
         results();
      end
   end
   // ********
   // Main sequence.
   // ********
   initial begin
      addrPin2 = 1'b0;
      eventCond = 8'h00;
      intMask = 8'h08;
      intTrigMode = {8'h00, 2'h3, TRIG_LEVEL, TRIG_REMOVE, TRIG_ARRIVE};
      intActiveHigh = 1'b1;
      intOpenDrain = 1'b0;
      blockStartIsInput = 1'b0;
      blockStartSyncIn = 1'b0;
      subframeStart = 1'b0;
      subframeIsFirst = 1'b0;
      userFromPin = 1'b0;
      userPin = 1'b0;
      userBufBit = 1'b0;
      tick(2);
      rst_b = 1'b1;
      tick(3);
      u_host.i2c_addr({I2C_ADDR_HI, 3'b011, 1'b0}, ack);
      chk(8'(ack), 8'h01);
      u_host.i2c_addr({I2C_ADDR_HI, 3'b001, 1'b0}, ack);
      chk(8'(ack), 8'h00);
      chk(8'(spiModeActive), 8'h00);
      userBufBit = 1'b1;
      tick(2);
      chk(8'(userBitOut), 8'h01);
      userFromPin = 1'b1;
      tick(4);
      chk(8'(userBitOut), 8'h00);
      for (int f = 1; f >= 0; f--) begin
         sub(f[0]);
         tick(1);
         chk({6'h0, blkOut, blkOe}, {6'h0, f[0], 1'b1});
      end
      blockStartIsInput = 1'b1;
      for (int n = 2; n <= 3; n++) begin
         blockStartSyncIn = 1'b1;
         tick(n);
         blockStartSyncIn = 1'b0;
         tick(4);
         sub(1'b0);
         chk({6'h0, blockRestart, blkOe}, 8'(n - 2 << 1));
      end
      eventCond = 8'h0F;
      tick(2);
      eventCond = 8'h00;
      tick(3);
      chk(intStatus, 8'h07);
      chk(8'(intOut), 8'h00);
      intMask = 8'hFF;
      tick(2);
      chk(8'(intOut), 8'h01);
      intActiveHigh = 1'b0;
      intOpenDrain = 1'b1;
      tick(1);
      chk({6'h0, intOut, intOe}, 8'h01);
      intActiveHigh = 1'b1;
      tick(1);
      chk({6'h0, intOut, intOe}, 8'h02);
      u_host.spi_read(st);
      chk(st, 8'h07);
      tick(2);
      chk({intStatus[6:0], intOut}, 8'h00);
      chk(8'(spiModeActive), 8'h01);
      results();
   end
endmodule
